// [design/ssp_port.sv]
// Synchronous late-write static memory port with pipeline and flow-through reads
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Address, data and read/write control are sampled only on the rising clock edge.
// - Sleep and output enable tri-state data at once; sleep stops accesses only through the two-stage synchroniser.
// - Each write is launched by a clock edge and timed internally, no write pulse.
// - Pipeline reads are held in an output register, driven after the next edge.
// - A configuration input selects registered pipeline or unregistered flow-through reads.
// - Write data follows address by two cycles pipelined, one cycle flow-through.
// - Writes are masked per nine-bit byte lane; only strobed lanes update.
// - The memory is selected only when all three chip selects are active.
// - Burst addresses follow linear or interleaved order per burst order select.
// - Sleep request powers the memory down; no accesses are performed meanwhile.
// - Stream mode select low picks flow-through, high picks pipeline.
// - Each byte lane has its own active low write strobe.
// - Second chip select is active high; first and third are active low.
// - Burst step advances the internal burst counter instead of loading an address.
module ssp_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Synchronous command pins
  input wire ssp_pkg::ssp_ctrl_t ctrl,
  // Static configuration and asynchronous pins
  input wire logic stream_mode_select,
  input wire logic burst_order_select,
  input wire logic sleep_request,
  input wire logic output_enable_n,
  // Data pins
  input wire logic [ssp_pkg::SSP_DATA_W-1:0] dq_in,
  output logic [ssp_pkg::SSP_DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  // Write queue status
  output logic write_buffer_ready
);
  import ssp_pkg::*;

  logic [SSP_SYNC_W-1:0] sync1_q;
  logic [SSP_SYNC_W-1:0] sync2_q;
  logic sleep_s;
  logic pipe_mode;
  logic interleave;

  logic selected;
  logic new_cmd;
  logic acc_step;
  logic acc_wr;
  logic acc_rd;
  logic [SSP_ADDR_W-1:0] base_src;
  logic [SSP_ADDR_W-1:0] access_addr;

  ssp_op_t op_q;
  ssp_op_t op_d;
  logic [SSP_ADDR_W-1:0] base_q;
  logic [SSP_ADDR_W-1:0] base_d;
  logic [SSP_BURST_W-1:0] cnt_q;
  logic [SSP_BURST_W-1:0] cnt_d;
  logic [SSP_BURST_W-1:0] low_bits;

  logic [SSP_DATA_W-1:0] mem_q [0:SSP_WORDS-1];
  logic [SSP_DATA_W-1:0] rd_stage_q;
  logic [SSP_DATA_W-1:0] rd_stage_d;
  logic [SSP_DATA_W-1:0] out_q;
  logic [SSP_DATA_W-1:0] out_d;
  logic rd_v1_q;
  logic rd_v1_d;
  logic rd_v2_q;
  logic rd_v2_d;
  logic drive_sync;

  ssp_wslot_t wp1_q;
  ssp_wslot_t wp1_d;
  ssp_wslot_t wp2_q;
  ssp_wslot_t wp2_d;
  ssp_wslot_t wsel;
  ssp_wentry_t fifo_in;
  ssp_wentry_t fifo_out;
  logic fifo_in_valid;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic drain;
  logic [SSP_DATA_W-1:0] old_word;

  // Configuration and sleep pins are not tied to the clock, so they are resynchronised
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_q <= SSP_SYNC_RST;
      sync2_q <= SSP_SYNC_RST;
    end
    else
    begin
      sync1_q <= {sleep_request, stream_mode_select, burst_order_select};
      sync2_q <= sync1_q;
    end
  end

  always_comb
  begin
    sleep_s = sync2_q[SSP_SYNC_SLEEP];
    pipe_mode = sync2_q[SSP_SYNC_MODE];
    interleave = sync2_q[SSP_SYNC_ORDER];
  end

  // Command decode and burst sequencing, all from pins sampled at the edge
  always_comb
  begin
    selected = !ctrl.chip_select_low_first_n && ctrl.chip_select_high
               && !ctrl.chip_select_low_second_n;
    new_cmd = !sleep_s && !ctrl.burst_step && selected;
    acc_step = !sleep_s && ctrl.burst_step && (op_q != SSP_OP_IDLE);
    acc_wr = new_cmd ? !ctrl.write_n : (acc_step && (op_q == SSP_OP_WRITE));
    acc_rd = (new_cmd || acc_step) && !acc_wr;
    op_d = op_q;
    base_d = base_q;
    cnt_d = cnt_q;
    if (new_cmd)
    begin
      op_d = ctrl.write_n ? SSP_OP_READ : SSP_OP_WRITE;
      base_d = ctrl.addr;
      cnt_d = SSP_BURST_RST;
    end
    else if (acc_step)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else
    begin
      op_d = SSP_OP_IDLE;
    end
    base_src = new_cmd ? ctrl.addr : base_q;
    // Only the two low bits walk, the burst wraps inside its group of four
    low_bits = interleave ? (base_src[SSP_BURST_W-1:0] ^ cnt_d)
                          : (base_src[SSP_BURST_W-1:0] + cnt_d);
    access_addr = {base_src[SSP_ADDR_W-1:SSP_BURST_W], low_bits};
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      op_q <= SSP_OP_IDLE;
      base_q <= SSP_ADDR_RST;
      cnt_q <= SSP_BURST_RST;
    end
    else
    begin
      op_q <= op_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
    end
  end

  // Read path: array read at the command edge, optional output register after it
  always_comb
  begin
    rd_v1_d = acc_rd;
    rd_stage_d = acc_rd ? mem_q[access_addr] : rd_stage_q;
    rd_v2_d = rd_v1_q;
    out_d = rd_v1_q ? rd_stage_q : out_q;
    drive_sync = pipe_mode ? rd_v2_q : rd_v1_q;
    dq_out = pipe_mode ? out_q : rd_stage_q;
    // The raw pins act here with no clock in the path
    dq_oe_n = !(drive_sync && !output_enable_n && !sleep_request);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_v1_q <= 1'b0;
      rd_v2_q <= 1'b0;
      rd_stage_q <= SSP_DATA_RST;
      out_q <= SSP_DATA_RST;
    end
    else
    begin
      rd_v1_q <= rd_v1_d;
      rd_v2_q <= rd_v2_d;
      rd_stage_q <= rd_stage_d;
      out_q <= out_d;
    end
  end

  // Late-write slots wait for the data, which comes one or two edges later
  always_comb
  begin
    wp1_d.valid = acc_wr;
    wp1_d.addr = access_addr;
    wp1_d.byte_write_n = ctrl.byte_write_n;
    wp2_d = wp1_q;
    wsel = pipe_mode ? wp2_q : wp1_q;
    fifo_in_valid = wsel.valid;
    fifo_in.addr = wsel.addr;
    fifo_in.byte_write_n = wsel.byte_write_n;
    fifo_in.data = dq_in;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wp1_q <= '0;
      wp2_q <= '0;
    end
    else
    begin
      wp1_q <= wp1_d;
      wp2_q <= wp2_d;
    end
  end

  // Queue decouples the pin timing from the array port; a full queue drops writes
  ssp_fifo #(
    .WIDTH(SSP_WENTRY_W),
    .DEPTH(SSP_FIFO_DEPTH)
  ) u_wqueue (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(write_buffer_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // Sleeping stalls the array; accesses stop too, so at most three writes wait in the queue: one already queued and the two slotted
  always_comb
  begin
    fifo_out_ready = !sleep_s;
    drain = fifo_out_valid && fifo_out_ready;
    old_word = mem_q[fifo_out.addr];
  end

  // Limitation: a read of a word still in the queue returns the older contents
  always_ff @(posedge clk_sys)
  begin
    if (drain)
    begin
      for (int k = 0; k < SSP_LANES; k++)
      begin
        if (!fifo_out.byte_write_n[k])
        begin
          mem_q[fifo_out.addr][k*SSP_LANE_W +: SSP_LANE_W] <=
            fifo_out.data[k*SSP_LANE_W +: SSP_LANE_W];
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_read_taken;
    acc_rd && pipe_mode && $stable(pipe_mode);
  endsequence

  sequence s_flow_read_taken;
    acc_rd && !pipe_mode && $stable(pipe_mode);
  endsequence

  sequence s_write_taken;
    acc_wr && $stable(pipe_mode);
  endsequence

  a_oe_override: assert property (output_enable_n |-> dq_oe_n)
    else $error("data pins driven while output enable is off");

  a_pipe_latency: assert property (s_read_taken |-> ##2 drive_sync)
    else $error("pipelined read not driven two edges after its address");

  a_pipe_data: assert property (s_read_taken ##1 pipe_mode |=> dq_out == $past(rd_stage_q))
    else $error("pipelined output register does not hold the read word");

  a_flow_latency: assert property (s_flow_read_taken |=> drive_sync)
    else $error("flow-through read not driven one edge after its address");

  a_write_lag: assert property (s_write_taken |-> if (pipe_mode) (##2 fifo_in_valid)
                                                  else (##1 fifo_in_valid))
    else $error("write data not captured at its late-write slot");

  a_chip_select: assert property (new_cmd |-> !ctrl.chip_select_low_first_n
                                  && ctrl.chip_select_high && !ctrl.chip_select_low_second_n)
    else $error("access taken without all chip selects active");

  a_burst_count: assert property (acc_step |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("burst counter did not advance by one");

  a_burst_order: assert property (acc_step && interleave |-> access_addr[1:0]
                                  == (base_q[1:0] ^ (cnt_q + 2'h1)))
    else $error("interleaved burst address wrong");

  a_sleep_idle: assert property (sleep_s |-> !new_cmd && !acc_step ##1 !rd_v1_q)
    else $error("access performed while asleep");

  a_byte_mask: assert property (drain && fifo_out.byte_write_n[0]
                                |=> mem_q[$past(fifo_out.addr)][8:0] == $past(old_word[8:0]))
    else $error("unstrobed lane was written");

endmodule // ssp_port
`default_nettype wire

// [design/ssp_pkg.sv]
// Shared constants and carriers for the synchronous late-write memory port
package ssp_pkg;

  localparam int SSP_ADDR_W = 10;
  localparam int SSP_LANES = 4;
  localparam int SSP_LANE_W = 9;
  localparam int SSP_DATA_W = SSP_LANES * SSP_LANE_W;
  localparam int SSP_WORDS = 1 << SSP_ADDR_W;
  localparam int SSP_FIFO_DEPTH = 8;
  localparam int SSP_BURST_W = 2;
  localparam int SSP_SYNC_W = 3;

  // Positions inside the pin synchroniser
  localparam int SSP_SYNC_ORDER = 0;
  localparam int SSP_SYNC_MODE = 1;
  localparam int SSP_SYNC_SLEEP = 2;

  // Write data lag behind its address, in clock cycles
  localparam int SSP_LAG_FLOW = 1;
  localparam int SSP_LAG_PIPE = 2;

  // Reset values
  localparam logic [SSP_BURST_W-1:0] SSP_BURST_RST = 2'h0;
  localparam logic [SSP_SYNC_W-1:0] SSP_SYNC_RST = 3'h0;
  localparam logic [SSP_ADDR_W-1:0] SSP_ADDR_RST = 10'h000;
  localparam logic [SSP_DATA_W-1:0] SSP_DATA_RST = 36'h0_0000_0000;

  typedef enum logic [1:0] {SSP_OP_IDLE, SSP_OP_READ, SSP_OP_WRITE} ssp_op_t;

  // Synchronous control pins, sampled on the rising clock edge
  typedef struct packed {
    logic [SSP_ADDR_W-1:0] addr;
    logic write_n;
    logic [SSP_LANES-1:0] byte_write_n;
    logic chip_select_low_first_n;
    logic chip_select_high;
    logic chip_select_low_second_n;
    logic burst_step;
  } ssp_ctrl_t;

  // Write waiting for its late data
  typedef struct packed {
    logic valid;
    logic [SSP_ADDR_W-1:0] addr;
    logic [SSP_LANES-1:0] byte_write_n;
  } ssp_wslot_t;

  // Complete write queued for the array
  typedef struct packed {
    logic [SSP_ADDR_W-1:0] addr;
    logic [SSP_LANES-1:0] byte_write_n;
    logic [SSP_DATA_W-1:0] data;
  } ssp_wentry_t;

  localparam int SSP_WENTRY_W = $bits(ssp_wentry_t);

endpackage

// [design/ssp_fifo.sv]
// Parameterised valid/ready FIFO for queued writes
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [0:DEPTH-1];
  logic [PW:0] wr_ptr_q;
  logic [PW:0] wr_ptr_d;
  logic [PW:0] rd_ptr_q;
  logic [PW:0] rd_ptr_d;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty without a counter
  always_comb
  begin
    in_ready = !((wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]));
    out_valid = (wr_ptr_q != rd_ptr_q);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    out_data = store_q[rd_ptr_q[PW-1:0]];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      store_q[wr_ptr_q[PW-1:0]] <= in_data;
    end
  end

endmodule // ssp_fifo
`default_nettype wire

// [sim/ssp_ctrl_model.sv]
// Memory controller model driving command pins and late write data
`timescale 1ns/1ps
`default_nettype none
module ssp_ctrl_model (
  // Clock and mode
  input wire logic clk_sys,
  input wire logic pipe,
  // Pins toward the memory
  output ssp_pkg::ssp_ctrl_t ctrl,
  output logic [ssp_pkg::SSP_DATA_W-1:0] drv,
  output logic drv_en
);
  import ssp_pkg::*;
  logic [2:0] wv;
  logic [SSP_DATA_W-1:0] wd [3];
  initial
  begin
    // Idle is a deselected read
    ctrl = 19'h001FA;
    wv = 3'h0;
  end
  // Data rides a delay line so it lands one or two edges after its address
  always @(posedge clk_sys)
  begin
    wv[2:1] <= wv[1:0];
    wd[2] <= wd[1];
    wd[1] <= wd[0];
  end
  assign drv_en = pipe ? wv[2] : wv[1];
  assign drv = pipe ? wd[2] : wd[1];
  task automatic issue(input ssp_ctrl_t c, input logic w, input logic [SSP_DATA_W-1:0] d);
  begin
    @(posedge clk_sys);
    ctrl <= c;
    wv[0] <= w;
    wd[0] <= d;
  end
  endtask
endmodule // ssp_ctrl_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the late-write memory port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssp_pkg::*;
  localparam logic [2:0] SEL = 3'h2;
  localparam int LIMIT = 5000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic pipe = 1'b1;
  logic order = 1'b0;
  logic sleep_request = 1'b0;
  logic output_enable_n = 1'b0;
  ssp_ctrl_t ctrl;
  logic [SSP_DATA_W-1:0] dq_in, dq_out, drv;
  logic dq_oe_n, write_buffer_ready, drv_en, due;
  int cyc = 0;
  int miscompares = 0;
  int samples_checked = 0;
  logic [SSP_DATA_W-1:0] exp_mem [SSP_WORDS];
  logic [SSP_DATA_W-1:0] exp_q [$];
  int due_q [$];
  logic [SSP_ADDR_W-1:0] bbase;
  logic [1:0] bcnt;
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Undriven bus shows a pattern that flips every cycle
  assign dq_in = !dq_oe_n ? dq_out : (drv_en ? drv : ({SSP_DATA_W{cyc[0]}} ^ 36'hA_5A5A_5A5A));
  ssp_port DUT (.clk_sys(clk_sys), .reset(reset), .ctrl(ctrl), .stream_mode_select(pipe),
    .burst_order_select(order), .sleep_request(sleep_request),
    .output_enable_n(output_enable_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .write_buffer_ready(write_buffer_ready));
  ssp_ctrl_model PM (.clk_sys(clk_sys), .pipe(pipe), .ctrl(ctrl), .drv(drv), .drv_en(drv_en));
  task automatic close_out();
  begin
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc > LIMIT)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk_data(input logic [SSP_DATA_W-1:0] got, input logic [SSP_DATA_W-1:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Judge the pins in mid-cycle, where they have settled
  always @(negedge clk_sys)
  begin
    if (!reset)
    begin
      due = due_q.size() > 0 && due_q[0] == cyc;
      chk_bit(dq_oe_n, !(due && !output_enable_n && !sleep_request));
      chk_bit(write_buffer_ready, 1'b1);
      if (due)
      begin
        if (!output_enable_n)
          chk_data(dq_out, exp_q[0]);
        void'(exp_q.pop_front());
        void'(due_q.pop_front());
      end
    end
  end
  task automatic op(input logic [SSP_ADDR_W-1:0] a, input logic wr_n, input logic [3:0] bw,
    input logic [2:0] cs, input logic step, input logic [SSP_DATA_W-1:0] d);
    logic [SSP_ADDR_W-1:0] ea;
    logic act;
  begin
    ea = a;
    act = ((cs == SEL) || step) && !sleep_request;
    if (step)
    begin
      bcnt++;
      ea = {bbase[SSP_ADDR_W-1:2], order ? bbase[1:0] ^ bcnt : bbase[1:0] + bcnt};
    end
    else
    begin
      bbase = a;
      bcnt = 2'h0;
    end
    PM.issue({a, wr_n, bw, cs, step}, !wr_n, d);
    for (int k = 0; k < SSP_LANES; k++)
      if (act && !wr_n && !bw[k])
        exp_mem[ea][k*SSP_LANE_W +: SSP_LANE_W] = d[k*SSP_LANE_W +: SSP_LANE_W];
    if (act && wr_n)
    begin
      exp_q.push_back(exp_mem[ea]);
      due_q.push_back(cyc + 1 + (pipe ? SSP_LAG_PIPE : SSP_LAG_FLOW));
    end
  end
  endtask
  task automatic idle(input int n);
  begin
    repeat (n) op(SSP_ADDR_RST, 1'b1, 4'hF, 3'h5, 1'b0, SSP_DATA_RST);
  end
  endtask
  task automatic do_reset(input logic p, input logic o);
  begin
    chk_bit(due_q.size() == 0, 1'b1);
    @(posedge clk_sys);
    reset <= 1'b1;
    pipe <= p;
    order <= o;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
  end
  endtask
  task automatic t_rw();
  begin
    for (logic [2:0] i = 0; i < 4; i++)
      op(10'h010 + i, 1'b0, 4'h0, SEL, 1'b0, 36'h1_2345_6780 + i);
    idle(4);
    // A read answers one cycle before a write right after it would fill, so the gap there is spare
    for (logic [2:0] i = 0; i < 4; i++)
    begin
      op(10'h020 + i, 1'b0, 4'h0, SEL, 1'b0, 36'hF_0F0F_0F00 ^ i);
      op(10'h010 + i, 1'b1, 4'hF, SEL, 1'b0, SSP_DATA_RST);
      idle(1);
    end
    idle(4);
    for (logic [2:0] i = 0; i < 4; i++)
      op(10'h020 + i, 1'b1, 4'hF, SEL, 1'b0, SSP_DATA_RST);
    idle(4);
    $display("Test rw done");
  end
  endtask
  task automatic t_lanes();
  begin
    for (logic [2:0] k = 0; k < 4; k++)
      op(10'h040 + k, 1'b0, 4'h0, SEL, 1'b0, SSP_DATA_RST);
    for (logic [2:0] k = 0; k < 4; k++)
      op(10'h040 + k, 1'b0, ~(4'h1 << k), SEL, 1'b0, 36'hF_FFFF_FFFF);
    idle(4);
    for (logic [2:0] k = 0; k < 4; k++)
      op(10'h040 + k, 1'b1, 4'hF, SEL, 1'b0, SSP_DATA_RST);
    idle(4);
    $display("Test lanes done");
  end
  endtask
  task automatic t_select();
  begin
    for (logic [3:0] c = 0; c < 8; c++)
      op(10'h060 + c, 1'b0, 4'h0, SEL, 1'b0, SSP_DATA_RST);
    for (logic [3:0] c = 0; c < 8; c++)
      op(10'h060 + c, 1'b0, 4'h0, c[2:0], 1'b0, 36'hA_AAAA_AAA0 | c);
    idle(4);
    for (logic [3:0] c = 0; c < 8; c++)
    begin
      op(10'h060 + c, 1'b1, 4'hF, c[2:0], 1'b0, SSP_DATA_RST);
      op(10'h060 + c, 1'b1, 4'hF, SEL, 1'b0, SSP_DATA_RST);
    end
    idle(4);
    $display("Test select done");
  end
  endtask
  task automatic t_burst();
  begin
    op(10'h085, 1'b0, 4'h0, SEL, 1'b0, 36'h5_0000_0000);
    for (logic [2:0] n = 1; n < 4; n++)
      op(10'h3FF, 1'b0, 4'h0, SEL, 1'b1, 36'h5_0000_0000 + n);
    idle(4);
    op(10'h086, 1'b1, 4'hF, SEL, 1'b0, SSP_DATA_RST);
    for (logic [2:0] n = 1; n < 4; n++)
      op(10'h3FF, 1'b1, 4'hF, SEL, 1'b1, SSP_DATA_RST);
    idle(4);
    $display("Test burst done");
  end
  endtask
  task automatic t_sleep_oe();
  begin
    @(posedge clk_sys);
    sleep_request <= 1'b1;
    idle(3);
    op(10'h010, 1'b0, 4'h0, SEL, 1'b0, SSP_DATA_RST);
    op(10'h010, 1'b1, 4'hF, SEL, 1'b0, SSP_DATA_RST);
    idle(3);
    sleep_request <= 1'b0;
    idle(4);
    for (logic [3:0] i = 0; i < 8; i++)
    begin
      op(10'h010 + i[1:0], 1'b1, 4'hF, SEL, 1'b0, SSP_DATA_RST);
      output_enable_n <= i[1];
    end
    idle(4);
    output_enable_n <= 1'b0;
    $display("Test sleep and output enable done");
  end
  endtask
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      do_reset(m[0], m[1]);
      t_rw();
      t_lanes();
      t_select();
      t_burst();
      t_sleep_oe();
    end
    do_reset(1'b1, 1'b0);
    close_out();
  end
endmodule // tb
`default_nettype wire
